// ==== core/chc_regs.svh ====
/*
  Timing constants and rule overview for the card host control block.
  Assumes a 50 MHz system clock; included by the package and modules.
*/
// Overview of operation
// - In memory mode host pulses read strobe; card drives data meanwhile.
// - Host ties mode-select low to enter direct ATA mode.
// - Host starts no access while ready/busy shows busy after reset.
// - Space-select high for common memory, low for attribute memory.
// - Host holds space-select low during I/O cycles.
// - Direct ATA mode host asserts DMA grant to accept pending request.
// - Card drives wait low to stretch cycle; host must not complete it.
`ifndef CHC_REGS_SVH
`define CHC_REGS_SVH
`define CHC_CLK_NS 20
`define CHC_RST_PULSE_NS 1000
`define CHC_RST_CYC ((`CHC_RST_PULSE_NS + `CHC_CLK_NS - 1) / `CHC_CLK_NS)
`define CHC_STROBE_NS 100
`define CHC_STROBE_CYC ((`CHC_STROBE_NS + `CHC_CLK_NS - 1) / `CHC_CLK_NS)
`define CHC_SETUP_CYC 2
`define CHC_CNT_W 8
`define CHC_MODE_MEM 2'h0
`define CHC_MODE_IO 2'h1
`define CHC_MODE_ATA 2'h2
`endif

// ==== core/chc_pkg.sv ====
/*
  Types for the card host control block.
  Assumes chc_regs.svh is on the include path.
*/
`include "chc_regs.svh"
package chc_pkg;
  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_WAIT_READY = 3'b001,
    ST_IDLE = 3'b010,
    ST_SETUP = 3'b011,
    ST_STROBE = 3'b100,
    ST_STRETCH = 3'b101,
    ST_HOLD = 3'b110
  } chc_state_type;
  typedef logic [1:0] chc_mode_type;
endpackage

// ==== core/chc_irq_if.sv ====
/*
  Interface carrying the normalised card event signals between modules.
  Assumes a single clock domain owned by the host controller.
*/
`timescale 1ns/1ns
interface chc_irq_if;
  logic irq_pulse;
  logic irq_level;
  logic dma_req;
  modport src (output irq_pulse, output irq_level, output dma_req);
  modport dst (input irq_pulse, input irq_level, input dma_req);
endinterface

// ==== core/chc_event_rx.sv ====
/*
  Mode-aware decoder of the card interrupt and DMA request lines.
  Assumes card outputs are synchronous to clk_i.
*/
`timescale 1ns/1ns
`include "chc_regs.svh"
module chc_event_rx
  import chc_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire chc_mode_type mode_i,
  input wire logic card_interrupt_request_n_i,
  input wire logic ata_interrupt_line_i,
  input wire logic dma_request_line_i,
  chc_irq_if.src ev
);
  logic req_n_prev_reg;
  wire is_io = (mode_i == `CHC_MODE_IO);
  wire is_ata = (mode_i == `CHC_MODE_ATA);
  // Falling edge catches pulse mode; level still reported for level mode
  wire fall = req_n_prev_reg & ~card_interrupt_request_n_i;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      req_n_prev_reg <= 1'b1;
      ev.irq_pulse <= 1'b0;
      ev.irq_level <= 1'b0;
      ev.dma_req <= 1'b0;
    end else begin
      req_n_prev_reg <= card_interrupt_request_n_i;
      ev.irq_pulse <= is_io & fall;
      ev.irq_level <= (is_io & ~card_interrupt_request_n_i) | (is_ata & ata_interrupt_line_i);
      ev.dma_req <= is_ata & dma_request_line_i;
    end
  end
  irq_pulse_once_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ev.irq_pulse |=> !ev.irq_pulse) else $error("irq pulse longer than one cycle");
endmodule

// ==== core/chc_host.sv ====
/*
  Host controller for the card parallel port control signals: reset, ready wait,
  read strobe with wait stretching, space select, DMA grant and interrupt sensing.
  Assumes card outputs are already synchronous to clk_i; data/address buses external.
*/
`timescale 1ns/1ns
`include "chc_regs.svh"
module chc_host
  import chc_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [1:0] mode_i,
  input wire logic card_reset_req_i,
  input wire logic rd_req_i,
  input wire logic rd_attr_i,
  input wire logic dma_accept_i,
  input wire logic ready_busy_line_i,
  input wire logic wait_n_i,
  input wire logic card_interrupt_request_n_i,
  input wire logic ata_interrupt_line_i,
  input wire logic dma_request_line_i,
  output logic direct_ata_mode_select_n_o,
  output logic card_reset_o,
  output logic read_strobe_n_o,
  output logic space_select_n_o,
  output logic dma_grant_n_o,
  output logic card_ready_o,
  output logic rd_done_o,
  output logic irq_o,
  output logic dma_pending_o
);
  chc_state_type state_reg, state_next;
  logic [`CHC_CNT_W-1:0] cnt_reg, cnt_next;
  chc_mode_type mode_reg;
  chc_irq_if ev ();

  chc_event_rx u_event_rx (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .mode_i(mode_reg),
    .card_interrupt_request_n_i(card_interrupt_request_n_i),
    .ata_interrupt_line_i(ata_interrupt_line_i),
    .dma_request_line_i(dma_request_line_i),
    .ev(ev)
  );

  function automatic logic cnt_done(input logic [`CHC_CNT_W-1:0] c);
    cnt_done = (c == '0);
  endfunction

  wire is_ata = (mode_reg == `CHC_MODE_ATA);
  wire is_io = (mode_reg == `CHC_MODE_IO);
  // Read strobe serves only attribute space in I/O mode
  wire rd_ok = rd_req_i & ~is_ata & (~is_io | rd_attr_i);
  wire in_reset = (state_reg == ST_RESET);
  wire in_read = (state_reg == ST_SETUP) || (state_reg == ST_STROBE) || (state_reg == ST_STRETCH);
  // Wait only honoured while strobe asserted
  wire stretch = ~wait_n_i;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    if (!cnt_done(cnt_reg)) begin
      cnt_next = cnt_reg - `CHC_CNT_W'(1);
    end
    unique case (state_reg)
      ST_RESET: begin
        if (cnt_done(cnt_reg)) begin
          state_next = ST_WAIT_READY;
        end
      end
      ST_WAIT_READY: begin
        // No access while card reports busy
        if (ready_busy_line_i) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (card_reset_req_i) begin
          state_next = ST_RESET;
          cnt_next = `CHC_CNT_W'(`CHC_RST_CYC - 1);
        end else if (rd_ok) begin
          state_next = ST_SETUP;
          cnt_next = `CHC_CNT_W'(`CHC_SETUP_CYC - 1);
        end
      end
      ST_SETUP: begin
        if (cnt_done(cnt_reg)) begin
          state_next = ST_STROBE;
          cnt_next = `CHC_CNT_W'(`CHC_STROBE_CYC - 1);
        end
      end
      ST_STROBE: begin
        if (cnt_done(cnt_reg)) begin
          state_next = stretch ? ST_STRETCH : ST_HOLD;
        end
      end
      ST_STRETCH: begin
        if (!stretch) begin
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_RESET;
        cnt_next = `CHC_CNT_W'(`CHC_RST_CYC - 1);
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_RESET;
      cnt_reg <= `CHC_CNT_W'(`CHC_RST_CYC - 1);
      mode_reg <= `CHC_MODE_MEM;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      // Mode changes only when card is held in reset
      if (state_next == ST_RESET) begin
        mode_reg <= mode_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      direct_ata_mode_select_n_o <= 1'b1;
      card_reset_o <= 1'b1;
      read_strobe_n_o <= 1'b1;
      space_select_n_o <= 1'b1;
      dma_grant_n_o <= 1'b1;
      card_ready_o <= 1'b0;
      rd_done_o <= 1'b0;
      irq_o <= 1'b0;
      dma_pending_o <= 1'b0;
    end else begin
      direct_ata_mode_select_n_o <= ~(mode_reg == `CHC_MODE_ATA);
      // ATA mode reset is active low; other modes active high
      card_reset_o <= is_ata ? ~in_reset : in_reset;
      read_strobe_n_o <= ~((state_next == ST_STROBE) || (state_next == ST_STRETCH));
      // Attribute or I/O space selects low across whole cycle
      space_select_n_o <= ~(in_read && (rd_attr_i || is_io));
      dma_grant_n_o <= ~(is_ata & ev.dma_req & dma_accept_i);
      card_ready_o <= (state_reg == ST_IDLE) & ready_busy_line_i;
      rd_done_o <= (state_reg == ST_HOLD);
      irq_o <= ev.irq_pulse | ev.irq_level;
      dma_pending_o <= ev.dma_req;
    end
  end

  sequence strobe_start_s;
    $fell(read_strobe_n_o);
  endsequence
  sequence strobe_min_s;
    !read_strobe_n_o [*5];
  endsequence

  strobe_width_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    strobe_start_s |-> strobe_min_s) else $error("read strobe shorter than minimum");
  wait_stretch_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_reg == ST_STRETCH && !wait_n_i) |=> !read_strobe_n_o) else $error("cycle ended under wait");
  busy_no_access_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_reg == ST_WAIT_READY) |-> read_strobe_n_o) else $error("access while card busy");
  io_strobe_attr_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (is_io && !read_strobe_n_o) |-> !space_select_n_o) else $error("io strobe outside attribute space");
  ata_no_strobe_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (is_ata && state_reg == ST_IDLE) |=> read_strobe_n_o) else $error("read strobe in ATA mode");
  direct_ata_mode_select_n_low_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (is_ata && $past(is_ata)) |-> !direct_ata_mode_select_n_o) else $error("ATA select not low");
  reset_level_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (in_reset && $past(in_reset) && !is_ata && $past(mode_reg) == mode_reg) |-> card_reset_o)
    else $error("card reset not high");
  grant_needs_req_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(dma_grant_n_o) |-> $past(ev.dma_req)) else $error("grant without request");
  io_space_low_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (is_io && state_reg == ST_STROBE) |=> !space_select_n_o) else $error("space select high in io cycle");
endmodule

// ==== test/chc_card_model.sv ====
/*
  Behavioural card for the host control bench: reset busy time, wait, events.
  Assumes the bench supplies the card's I/O configuration and event stimulus.
*/
`timescale 1ns/1ns
module chc_card_model (
  input wire logic clk_i,
  input wire logic direct_ata_mode_select_n_n_i,
  input wire logic card_reset_i,
  input wire logic strobe_n_i,
  input wire logic io_i,
  input wire logic irq_i,
  input wire logic dma_i,
  input wire logic [3:0] wait_len_i,
  output logic ready_busy_o,
  output logic wait_n_o,
  output logic irq_n_o,
  output logic ata_irq_o,
  output logic dma_req_o
);
  logic ata, in_rst, strobe_q, power_rst;
  int busy = 20;
  int wcnt = 0;
  assign ata = !direct_ata_mode_select_n_n_i;
  assign in_rst = ata ? !card_reset_i : card_reset_i;
  assign irq_n_o = !(irq_i && io_i && !ata);
  assign ata_irq_o = irq_i && ata;
  assign wait_n_o = (wcnt == 0);
  initial begin
    strobe_q = 1'b1;
    power_rst = 1'b1;
    ready_busy_o = 1'b0;
    dma_req_o = 1'b0;
  end
  always @(posedge clk_i) begin
    strobe_q <= strobe_n_i;
    // Reset held since power-up counts as the one power-up reset only
    if (in_rst === 1'b0) begin
      power_rst <= 1'b0;
    end
    if (in_rst && !power_rst) begin
      busy <= 20;
    end else if (busy > 0) begin
      busy <= busy - 1;
    end
    ready_busy_o <= (power_rst && in_rst) || (!in_rst && busy == 0);
    // Stretch only memory cycles
    if (strobe_q && !strobe_n_i && !ata && !io_i) begin
      wcnt <= wait_len_i;
    end else if (wcnt > 0) begin
      wcnt <= wcnt - 1;
    end
    dma_req_o <= dma_i && ata;
  end
endmodule

// ==== test/chc_host_tb_top.sv ====
/*
  Self-checking bench for chc_host with a behavioural card attached.
  Assumes the package and header are compiled first.
*/
`timescale 1ns/1ns
`include "chc_regs.svh"
module chc_host_tb_top;
  logic clk = 1'b0, rst = 1'b1, rreq = 1'b0, rrd = 1'b0, attr = 1'b0, acc = 1'b0;
  logic io = 1'b0, irq = 1'b0, dma = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [3:0] wlen = 4'h0;
  logic sel_n, crst, strb_n, ss_n, gnt_n, rdy, done, irq_o, dpend, rb, w_n, irq_n, airq, dreq;
  int mismatches = 0, check_count = 0, cyc = 0;
  always #10 clk = ~clk;
  chc_host uut (.clk_i(clk), .sys_rst_i(rst), .mode_i(mode), .card_reset_req_i(rreq), .rd_req_i(rrd),
    .rd_attr_i(attr), .dma_accept_i(acc), .ready_busy_line_i(rb), .wait_n_i(w_n),
    .card_interrupt_request_n_i(irq_n), .ata_interrupt_line_i(airq), .dma_request_line_i(dreq),
    .direct_ata_mode_select_n_o(sel_n), .card_reset_o(crst), .read_strobe_n_o(strb_n),
    .space_select_n_o(ss_n), .dma_grant_n_o(gnt_n), .card_ready_o(rdy), .rd_done_o(done),
    .irq_o(irq_o), .dma_pending_o(dpend));
  chc_card_model card (.clk_i(clk), .direct_ata_mode_select_n_n_i(sel_n), .card_reset_i(crst), .strobe_n_i(strb_n),
    .io_i(io), .irq_i(irq), .dma_i(dma), .wait_len_i(wlen), .ready_busy_o(rb), .wait_n_o(w_n),
    .irq_n_o(irq_n), .ata_irq_o(airq), .dma_req_o(dreq));
  task automatic chk(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Whole run needs about 780 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic reset_card(input logic [1:0] m);
    int held, early;
    held = 0;
    early = 0;
    mode = m;
    io = (m == `CHC_MODE_IO);
    rreq = 1'b1;
    @(negedge clk);
    rreq = 1'b0;
    repeat (150) begin
      @(negedge clk);
      if (crst === (m != `CHC_MODE_ATA)) held++;
      if (rdy === 1'b1 && rb !== 1'b1) early++;
    end
    chk(held >= `CHC_RST_CYC, 1'b1);
    chk(early == 0, 1'b1);
    chk(sel_n, m != `CHC_MODE_ATA);
    chk(rdy, 1'b1);
  endtask
  task automatic do_read(input logic a, input logic [3:0] wl, input logic ok);
    int low, bad, n;
    low = 0;
    bad = 0;
    n = 0;
    wlen = wl;
    attr = a;
    rrd = 1'b1;
    @(negedge clk);
    rrd = 1'b0;
    while (done !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
      if (strb_n === 1'b0) low++;
      if (strb_n === 1'b0 && ss_n !== !a) bad++;
    end
    chk(done, ok);
    chk(ok ? low >= ((wl > 4) ? wl + 1 : `CHC_STROBE_CYC) : low == 0, 1'b1);
    chk(bad == 0, 1'b1);
    @(negedge clk);
  endtask
  task automatic irq_check;
    logic seen;
    seen = 1'b0;
    irq = 1'b1;
    repeat (6) begin
      @(negedge clk);
      seen |= (irq_o === 1'b1);
    end
    chk(seen, 1'b1);
    irq = 1'b0;
    repeat (6) @(negedge clk);
    chk(irq_o, 1'b0);
  endtask
  task automatic dma_check;
    dma = 1'b1;
    repeat (4) @(negedge clk);
    chk(dpend, 1'b1);
    chk(gnt_n, 1'b1);
    acc = 1'b1;
    repeat (4) @(negedge clk);
    chk(gnt_n, 1'b0);
    dma = 1'b0;
    acc = 1'b0;
    repeat (4) @(negedge clk);
    chk(gnt_n, 1'b1);
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (150) @(negedge clk);
    chk(rdy, 1'b1);
    do_read(1'b0, 4'h0, 1'b1);
    do_read(1'b1, 4'h9, 1'b1);
    reset_card(`CHC_MODE_IO);
    do_read(1'b0, 4'h0, 1'b0);
    do_read(1'b1, 4'h0, 1'b1);
    irq_check();
    reset_card(`CHC_MODE_ATA);
    do_read(1'b1, 4'h0, 1'b0);
    irq_check();
    dma_check();
    reset_card(`CHC_MODE_MEM);
    do_read(1'b0, 4'h3, 1'b1);
    close_out();
  end
endmodule
